// ### ssr_defs.vh
// Purpose: constants for the serial shift and storage register block
// Assumes: clk at 100 MHz; all control pins asynchronous to clk
// Notes: three-stage pin synchronisers, two-entry buffer on the load path
`ifndef SSR_DEFS_VH
`define SSR_DEFS_VH
`define SSR_WIDTH      8
`define SSR_LAST_BIT   7
`define SSR_SYNC_DEPTH 3
`define SSR_RST_BYTE   8'h00
`define SSR_BUF_DEPTH  2
`define SSR_CLK_PERIOD_NS 10
`define SSR_LINK_PERIOD_NS 125
`define SSR_LINK_HALF_CYC (`SSR_LINK_PERIOD_NS / 2 / `SSR_CLK_PERIOD_NS)
`endif

// ### ssr_buf2.v
// Purpose: two-entry valid/ready buffer for captured storage bytes
// Assumes: single clock, source and sink in the clk domain
// Notes: full and empty are exact; in_ready low whenever both entries hold data
`timescale 1ns/1ps
`default_nettype none
`include "ssr_defs.vh"
module ssr_buf2
(
  input  wire                   clk,
  input  wire                   rst_b,
  input  wire [`SSR_WIDTH-1:0]  in_data,
  input  wire                   in_valid,
  output wire                   in_ready,
  output wire [`SSR_WIDTH-1:0]  out_data,
  output wire                   out_valid,
  input  wire                   out_ready
);
  reg [`SSR_WIDTH-1:0] mem_r [0:`SSR_BUF_DEPTH-1];
  reg                  wptr_r;
  reg                  rptr_r;
  reg [1:0]            cnt_r;
  wire                 push;
  wire                 pop;

  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mem_r[0] <= `SSR_RST_BYTE;
      mem_r[1] <= `SSR_RST_BYTE;
      wptr_r   <= 1'b0;
      rptr_r   <= 1'b0;
      cnt_r    <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        mem_r[wptr_r] <= in_data;
        wptr_r        <= ~wptr_r;
      end
      if (pop)
        rptr_r <= ~rptr_r;
      if (push && !pop)
        cnt_r <= cnt_r + 2'h1;
      else if (pop && !push)
        cnt_r <= cnt_r - 2'h1;
    end
  end
endmodule
`default_nettype wire

// ### ssr_top.v
// Purpose: serial-in, parallel-out shift register with storage register
// Assumes: pins are asynchronous to clk and pulses exceed two clk periods
// Notes: pin changes are seen about three clk cycles late
//        pin levels seen at fewer than two clk edges are dropped as glitches
`timescale 1ns/1ps
`default_nettype none
`include "ssr_defs.vh"
module ssr_top
(
  input  wire                   clk,
  input  wire                   rst_b,
  input  wire                   serial_in,
  input  wire                   shift_clock,
  input  wire                   storage_clock,
  input  wire                   shift_clear_n,
  input  wire                   output_enable_n,
  output reg  [`SSR_WIDTH-1:0]  parallel_outputs_o,
  output reg  [`SSR_WIDTH-1:0]  parallel_outputs_oe,
  output reg                    cascade_out,
  output reg                    cascade_out_oe
);
  // Sync chain reset patterns, matching each pin's idle level except clear, which resets low
  localparam [`SSR_SYNC_DEPTH-1:0] SYNC_LOW  = 3'h0;
  localparam [`SSR_SYNC_DEPTH-1:0] SYNC_HIGH = 3'h7;

  // Bit order of each sync chain: [0] first flop, [1] second, [2] third
  reg [`SSR_SYNC_DEPTH-1:0] ser_s_r;
  reg [`SSR_SYNC_DEPTH-1:0] sck_s_r;
  reg [`SSR_SYNC_DEPTH-1:0] rck_s_r;
  reg [`SSR_SYNC_DEPTH-1:0] clr_s_r;
  reg [`SSR_SYNC_DEPTH-1:0] oe_s_r;
  reg                       sck_r;
  reg                       rck_r;
  reg                       clr_n_r;
  reg                       oe_n_r;
  reg                       ser_r;
  reg [`SSR_WIDTH-1:0]      shift_r;
  reg [`SSR_WIDTH-1:0]      store_r;
  wire                      sck_rise;
  wire                      rck_rise;
  wire                      buf_in_ready;
  wire [`SSR_WIDTH-1:0]     buf_out_data;
  wire                      buf_out_valid;
  wire [`SSR_WIDTH-1:0]     cap_data;

  // A level is accepted only once the second and third flops agree
  function filt;
    input [`SSR_SYNC_DEPTH-1:0] s;
    input                       cur;
    begin
      filt = (s[1] == s[2]) ? s[2] : cur;
    end
  endfunction

  // High for the one sample in which a filtered level turns on
  function rise;
    input [`SSR_SYNC_DEPTH-1:0] s;
    input                       cur;
    begin
      rise = filt(s, cur) && !cur;
    end
  endfunction

  // Data pin; idles low like the controller's pin
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ser_s_r <= SYNC_LOW;
      ser_r   <= 1'b0;
    end
    else
    begin
      ser_s_r <= {ser_s_r[1:0], serial_in};
      ser_r   <= filt(ser_s_r, ser_r);
    end
  end

  // Shift clock pin; reset low so that no false edge follows reset
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sck_s_r <= SYNC_LOW;
      sck_r   <= 1'b0;
    end
    else
    begin
      sck_s_r <= {sck_s_r[1:0], shift_clock};
      sck_r   <= filt(sck_s_r, sck_r);
    end
  end

  // Storage clock pin; reset low so that no false edge follows reset
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rck_s_r <= SYNC_LOW;
      rck_r   <= 1'b0;
    end
    else
    begin
      rck_s_r <= {rck_s_r[1:0], storage_clock};
      rck_r   <= filt(rck_s_r, rck_r);
    end
  end

  // Clear pin; held asserted until the pin has been seen, so stages stay zero
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      clr_s_r <= SYNC_LOW;
      clr_n_r <= 1'b0;
    end
    else
    begin
      clr_s_r <= {clr_s_r[1:0], shift_clear_n};
      clr_n_r <= filt(clr_s_r, clr_n_r);
    end
  end

  // Enable pin; parallel outputs stay released until the pin has been seen low
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      oe_s_r <= SYNC_HIGH;
      oe_n_r <= 1'b1;
    end
    else
    begin
      oe_s_r <= {oe_s_r[1:0], output_enable_n};
      oe_n_r <= filt(oe_s_r, oe_n_r);
    end
  end

  // Rising edges only; the two clocks are detected separately
  assign sck_rise = rise(sck_s_r, sck_r);
  assign rck_rise = rise(rck_s_r, rck_r);

  // Serial data is taken from the value settled before the shift edge
  // Clear is a level and wins over a shift edge seen in the same cycle
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      shift_r <= `SSR_RST_BYTE;
    else if (!clr_n_r)
      shift_r <= `SSR_RST_BYTE;
    else if (sck_rise)
      shift_r <= {shift_r[`SSR_LAST_BIT-1:0], ser_r};
  end

  // Capture reads shift_r before the same-cycle shift lands
  // Under clear the stages read as zero at once, before shift_r has followed
  assign cap_data = clr_n_r ? shift_r : `SSR_RST_BYTE;

  // Stalls only if the buffer is full, which the drain below prevents
  // Trade-off: one cycle of latency on each capture, but none is ever dropped
  ssr_buf2 u_buf
  (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_data   (cap_data),
    .in_valid  (rck_rise),
    .in_ready  (buf_in_ready),
    .out_data  (buf_out_data),
    .out_valid (buf_out_valid),
    .out_ready (1'b1)
  );

  // The drain is always ready, so each word leaves the buffer one cycle later
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      store_r <= `SSR_RST_BYTE;
    else if (buf_out_valid)
      store_r <= buf_out_data;
  end

  // Open-drain view: data pin always low, enable asserted to pull low
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      parallel_outputs_o  <= 8'h00;
      parallel_outputs_oe <= 8'h00;
    end
    else
    begin
      parallel_outputs_o  <= 8'h00;
      parallel_outputs_oe <= oe_n_r ? 8'h00 : ~store_r;
    end
  end

  // Push-pull cascade pin; it ignores the enable so cascaded parts keep shifting
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cascade_out    <= 1'b0;
      cascade_out_oe <= 1'b1;
    end
    else
    begin
      cascade_out    <= shift_r[`SSR_LAST_BIT];
      cascade_out_oe <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### ssr_asserts.sv
// Purpose: port checks on ssr_top
// Assumes: pins hold each level for 6 clk or more
// Notes: 8 clk windows cover the three-flop pin sync
`timescale 1ns/1ps
`default_nettype none
module ssr_asserts
(
  input wire       clk,
  input wire       rst_b,
  input wire       shift_clock,
  input wire       storage_clock,
  input wire       shift_clear_n,
  input wire       output_enable_n,
  input wire [7:0] parallel_outputs_o,
  input wire [7:0] parallel_outputs_oe,
  input wire       cascade_out,
  input wire       cascade_out_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  never_high_a: assert property (parallel_outputs_o == 8'h00)
    else $error("data driven high");
  cascade_on_a: assert property (cascade_out_oe)
    else $error("cascade released");
  off_float_a: assert property (output_enable_n [*8] |-> ~|parallel_outputs_oe)
    else $error("disabled output pulls");
  off_soon_a: assert property ($rose(output_enable_n) |-> ##[1:8] ~|parallel_outputs_oe)
    else $error("slow disable");
  clear_zero_a: assert property (!shift_clear_n [*8] |-> !cascade_out)
    else $error("clear ignored");
  no_shift_a: assert property
    ((!shift_clock && shift_clear_n) [*8] |=> $stable(cascade_out)) else $error("stray shift");
  no_store_a: assert property
    ((!storage_clock && !output_enable_n) [*8] |=> $stable(parallel_outputs_oe))
    else $error("stray store");
  clear_keep_a: assert property
    ((!shift_clear_n && !output_enable_n && !storage_clock) [*8]
     |=> $stable(parallel_outputs_oe))
    else $error("clear hit storage");
  cover property ($rose(shift_clock) && $rose(storage_clock));
  cover property ($rose(storage_clock) && !shift_clear_n);
  cover property ($fell(output_enable_n));
endmodule
`default_nettype wire

// ### ssr_ctrl_model.sv
// Purpose: GPIO controller driving the pins of ssr_top
// Assumes: pins change 1 ns after a clk edge
// Notes: 6 clk per level, so every pin outlasts the sync, except the late serial_in flip held 1 clk
`timescale 1ns/1ps
`default_nettype none
module ssr_ctrl_model
(
  input  wire      clk,
  output var logic serial_in,
  output var logic shift_clock,
  output var logic storage_clock,
  output var logic shift_clear_n,
  output var logic output_enable_n
);
  initial
  begin
    {serial_in, shift_clock, storage_clock} = 3'h0;
    {shift_clear_n, output_enable_n} = 2'h3;
  end
  task automatic hold(input int n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task automatic set(input logic clr_n, input logic dis);
    begin
      {shift_clear_n, output_enable_n} = {clr_n, dis};
      hold(6);
    end
  endtask
  task automatic pulse(input logic sh, input logic st);
    begin
      hold(6);
      {shift_clock, storage_clock} = {sh, st};
      hold(5);
      // Late flip of the data pin; the filter drops it when the next bit follows
      serial_in = ~serial_in;
      hold(1);
      {shift_clock, storage_clock} = 2'h0;
    end
  endtask
  task automatic store;
    pulse(1'b0, 1'b1);
  endtask
  task automatic send_byte(input logic [7:0] v, input logic tie);
    for (int i = 7; i >= 0; i--)
    begin
      serial_in = v[i];
      pulse(1'b1, tie && i == 0);
    end
  endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// Purpose: self-checking bench for ssr_top
// Assumes: settle of 12 clk after each step
// Notes: notes of expected {parallel_outputs_o, parallel_outputs_oe, cascade_out, cascade_out_oe} wait in a queue
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  wire serial_in, shift_clock, storage_clock, shift_clear_n, output_enable_n;
  wire [7:0] parallel_outputs_o, parallel_outputs_oe;
  wire cascade_out, cascade_out_oe;
  logic [17:0] exp_q[$];
  logic [17:0] exp_v;
  logic [7:0] b, st;
  logic on = 1'b1;
  int fail_count = 0;
  int cmp_count = 0;
  event settle;
  always #5 clk = ~clk;
  ssr_ctrl_model m (.*);
  ssr_top dut (.*);
  task automatic note(input logic [7:0] s, input logic c);
    begin
      exp_q.push_back({8'h00, on ? ~s : 8'h00, c, 1'b1});
      m.hold(12);
      ->settle;
      // Let the checker run before the next step or the verdict
      m.hold(1);
    end
  endtask
  always @(settle)
  begin
    exp_v = exp_q.pop_front();
    cmp_count++;
    if ({parallel_outputs_o, parallel_outputs_oe, cascade_out, cascade_out_oe} !== exp_v)
    begin
      $display("unexpected outputs: expected %h seen %h", exp_v,
               {parallel_outputs_o, parallel_outputs_oe, cascade_out, cascade_out_oe});
      fail_count++;
    end
  end
  task automatic conclude;
    begin
      $display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial
  begin
    void'($urandom(15));
    m.hold(20);
    rst_b = 1'b1;
    m.set(1'b0, 1'b0);
    m.store();
    m.set(1'b1, 1'b0);
    note(8'h00, 1'b0);
    $display("test init done");
    repeat (4)
    begin
      b = 8'($urandom);
      m.send_byte(b, 1'b0);
      m.store();
      st = b;
      note(st, b[7]);
    end
    $display("test bytes done");
    b = 8'($urandom);
    st = {st[0], b[7:1]};
    m.send_byte(b, 1'b1);
    note(st, b[7]);
    $display("test shared clock done");
    on = 1'b0;
    m.set(1'b1, 1'b1);
    note(st, b[7]);
    $display("test disable done");
    on = 1'b1;
    m.set(1'b0, 1'b0);
    note(st, 1'b0);
    m.store();
    note(8'h00, 1'b0);
    m.set(1'b1, 1'b0);
    m.store();
    note(8'h00, 1'b0);
    $display("test clear done");
    conclude();
  end
  initial
  begin
    #200000;
    fail_count++;
    conclude();
  end
endmodule
bind ssr_top ssr_asserts chk (.*);
`default_nettype wire
